// [src/rx_decode_regs.vh]
// constants for the four-lane receive decode, deskew and elastic path
`ifndef RX_DECODE_REGS_VH
`define RX_DECODE_REGS_VH

// ---------------------------------------------------------------------------
// programmable character resets
// ---------------------------------------------------------------------------
`define IDLE_CHAR_RESET   8'h07
`define IDLE_COLUMN_RESET 9'h107
`define ERROR_CHAR_RESET  9'h1ff

// ---------------------------------------------------------------------------
// decoded control characters, control flag in bit 8
// ---------------------------------------------------------------------------
`define CHAR_K28_0 9'h11c
`define CHAR_K28_1 9'h13c
`define CHAR_K28_2 9'h15c
`define CHAR_K28_3 9'h17c
`define CHAR_K28_4 9'h19c
`define CHAR_K28_5 9'h1bc
`define CHAR_K28_6 9'h1dc
`define CHAR_K28_7 9'h1fc
`define CHAR_K23_7 9'h1f7
`define CHAR_K27_7 9'h1fb
`define CHAR_K29_7 9'h1fd
`define CHAR_K30_7 9'h1fe

// ---------------------------------------------------------------------------
// local fault ordered set per lane
// ---------------------------------------------------------------------------
`define LF_LANE0 9'h19c
`define LF_LANE1 9'h000
`define LF_LANE2 9'h000
`define LF_LANE3 9'h001

// ---------------------------------------------------------------------------
// code group fields, a first
// ---------------------------------------------------------------------------
`define SIX_K28_NEG 6'h0f
`define SIX_K28_POS 6'h30
`define FOUR_K7_NEG 4'h8
`define FOUR_K7_POS 4'h7
`define LO_K23      5'h17
`define LO_K27      5'h1b
`define LO_K29      5'h1d
`define LO_K30      5'h1e

// ---------------------------------------------------------------------------
// buffer entry layout: mark, idle, error, 9-bit character
// ---------------------------------------------------------------------------
`define ENT_MARK  11
`define ENT_IDLE  10
`define ENT_ERR   9
`define ENT_WIDTH 12

// ---------------------------------------------------------------------------
// receive clock select codes and buffer sizing
// ---------------------------------------------------------------------------
`define RCS_LOCAL    2'h0
`define RCS_PER_LANE 2'h1
`define RCS_LANE_A   2'h2
`define DESKEW_BYTES 8
`define COMP_BYTES   8
`define COMP_PPM     200
`define HYST_LIMIT   3'h3

`endif

// [src/lane_buffer.v]
// one lane's elastic buffer storage with registered read
`timescale 1ns/1ns
`default_nettype none

module lane_buffer #(
    parameter WIDTH      = 12,
    parameter ADDR_WIDTH = 4
) (
    input  wire                  sys_clk,
    input  wire                  arst_n,
    input  wire                  wr_en,
    input  wire [ADDR_WIDTH-1:0] wr_addr,
    input  wire [WIDTH-1:0]      wr_data,
    input  wire [ADDR_WIDTH-1:0] rd_addr,
    output reg  [WIDTH-1:0]      rd_data
);

    reg [WIDTH-1:0] mem [0:(1<<ADDR_WIDTH)-1];

    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= {WIDTH{1'b0}};
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

`default_nettype wire

// [src/rx_decode_deskew_elastic.v]
// four-lane receive decode, idle handling, deskew and clock compensation
//
// What this block does
// [RULE1] far end sends bits a b c d e i f g h j, a first.
// [RULE2] decoded character is A..H then control flag K, A least significant.
// [RULE3] with translation on, idle groups become programmed idle, default 107.
// [RULE4] without translation, K28.5, K28.3, K28.0 decode to BC, 7C, 1C controls.
// [RULE5] first full idle column after non-idle is stored and repeated; the code does this only while trunking.
// [RULE6] local fault in standard modes outputs sequence, 00, 00, 01 column.
// [RULE7] valid data groups give their byte with both flags clear.
// [RULE8] listed control groups decode to their characters, error clear.
// [RULE9] K30.7 gives FE with both flags; other invalid gives error character.
// [RULE10] standard lane mode forces idle translation on.
// [RULE11] each lane buffer keeps 8 entries for deskew.
// [RULE12] align when all lanes show boundary or align; hold until next.
// [RULE13] realignment may drop, repeat or corrupt up to four groups.
// [RULE14] deskew state machine on overrides simple alignment enable.
// [RULE15] simple alignment without state machine deskews without hysteresis.
// [RULE16] trunking only with coding active and equal half-rate settings.
// [RULE17] output paced by local clock, own lane clock, or lane A clock.
// [RULE18] each lane buffer keeps another 8 entries for compensation.
// [RULE19] idles are dropped or generated locally to match clock rates.
// [RULE20] compensation absorbs up to 200 ppm offset.
// [RULE21] far end sends alignment markers on all lanes within buffer span.
// [RULE22] non-trunking lanes run independently with no cross-lane alignment.
`timescale 1ns/1ns
`default_nettype none
`include "rx_decode_regs.vh"

module rx_decode_deskew_elastic #(
    parameter DESKEW_DEPTH = `DESKEW_BYTES,
    parameter COMP_DEPTH   = `COMP_BYTES,
    parameter ADDR_WIDTH   = 4
) (
    input  wire        sys_clk,
    input  wire        arst_n,
    input  wire [39:0] lane_code,
    input  wire [3:0]  lane_valid,
    input  wire        idle_translate_enable,
    input  wire        standard_lane_mode_enable,
    input  wire        standard_sync_select,
    input  wire        deskew_state_machine_enable,
    input  wire        simple_align_enable,
    input  wire [1:0]  receive_clock_select,
    input  wire        trunk_sync_pin,
    input  wire        coding_active,
    input  wire [3:0]  half_rate,
    input  wire [7:0]  idle_char,
    input  wire [8:0]  error_char,
    input  wire        local_fault,
    output reg  [35:0] rx_char,
    output reg  [3:0]  rx_err,
    output reg  [3:0]  rx_valid,
    output reg         lanes_aligned,
    output reg         trunk_active
);

    localparam LANES = 4;
    localparam [ADDR_WIDTH:0] DEPTH_CNT = DESKEW_DEPTH + COMP_DEPTH;
    localparam [ADDR_WIDTH:0] FILL_HIGH = DESKEW_DEPTH + COMP_DEPTH / 2;
    localparam [3:0]          STALL_LIMIT = DESKEW_DEPTH - 1;

    // -----------------------------------------------------------------------
    // code group decoder: {idle, align, error, char}
    // -----------------------------------------------------------------------
    function [11:0] decode_group;
        input [9:0] cg;
        input       translate;
        input [7:0] idle_val;
        input [8:0] err_val;
        reg   [5:0] six;
        reg   [3:0] four;
        reg   [3:0] kfour;
        reg   [4:0] lo;
        reg   [2:0] hi;
        reg         lo_ok;
        reg         hi_ok;
        reg   [8:0] idle_out;
        begin
            six      = {cg[0], cg[1], cg[2], cg[3], cg[4], cg[5]}; // RULE1
            four     = {cg[6], cg[7], cg[8], cg[9]};
            kfour    = (six == `SIX_K28_POS) ? ~four : four;
            lo_ok    = 1'b1;
            hi_ok    = 1'b1;
            lo       = 5'h00;
            hi       = 3'h0;
            idle_out = {1'b1, idle_val};
            case (six)
                6'b100111, 6'b011000: lo = 5'd0;
                6'b011101, 6'b100010: lo = 5'd1;
                6'b101101, 6'b010010: lo = 5'd2;
                6'b110001:            lo = 5'd3;
                6'b110101, 6'b001010: lo = 5'd4;
                6'b101001:            lo = 5'd5;
                6'b011001:            lo = 5'd6;
                6'b111000, 6'b000111: lo = 5'd7;
                6'b111001, 6'b000110: lo = 5'd8;
                6'b100101:            lo = 5'd9;
                6'b010101:            lo = 5'd10;
                6'b110100:            lo = 5'd11;
                6'b001101:            lo = 5'd12;
                6'b101100:            lo = 5'd13;
                6'b011100:            lo = 5'd14;
                6'b010111, 6'b101000: lo = 5'd15;
                6'b011011, 6'b100100: lo = 5'd16;
                6'b100011:            lo = 5'd17;
                6'b010011:            lo = 5'd18;
                6'b110010:            lo = 5'd19;
                6'b001011:            lo = 5'd20;
                6'b101010:            lo = 5'd21;
                6'b011010:            lo = 5'd22;
                6'b111010, 6'b000101: lo = 5'd23;
                6'b110011, 6'b001100: lo = 5'd24;
                6'b100110:            lo = 5'd25;
                6'b010110:            lo = 5'd26;
                6'b110110, 6'b001001: lo = 5'd27;
                6'b001110:            lo = 5'd28;
                6'b101110, 6'b010001: lo = 5'd29;
                6'b011110, 6'b100001: lo = 5'd30;
                6'b101011, 6'b010100: lo = 5'd31;
                default:              lo_ok = 1'b0;
            endcase
            case (four)
                4'b1011, 4'b0100:                   hi = 3'd0;
                4'b1001:                            hi = 3'd1;
                4'b0101:                            hi = 3'd2;
                4'b1100, 4'b0011:                   hi = 3'd3;
                4'b1101, 4'b0010:                   hi = 3'd4;
                4'b1010:                            hi = 3'd5;
                4'b0110:                            hi = 3'd6;
                4'b1110, 4'b0001, 4'b0111, 4'b1000: hi = 3'd7;
                default:                            hi_ok = 1'b0;
            endcase
            if (six == `SIX_K28_NEG || six == `SIX_K28_POS) begin
                case (kfour)
                    4'b0100: decode_group = {1'b1, 2'b00, translate ? idle_out : `CHAR_K28_0}; // RULE3 RULE4
                    4'b1001: decode_group = {3'b000, `CHAR_K28_1}; // RULE8
                    4'b0101: decode_group = {3'b000, `CHAR_K28_2}; // RULE8
                    4'b0011: decode_group = {2'b11, 1'b0, translate ? idle_out : `CHAR_K28_3}; // RULE3 RULE4
                    4'b0010: decode_group = {3'b000, `CHAR_K28_4}; // RULE8
                    4'b1010: decode_group = {1'b1, 2'b00, translate ? idle_out : `CHAR_K28_5}; // RULE3 RULE4
                    4'b0110: decode_group = {3'b000, `CHAR_K28_6}; // RULE8
                    4'b1000: decode_group = {3'b000, `CHAR_K28_7}; // RULE8
                    default: decode_group = {3'b001, err_val}; // RULE9
                endcase
            end else if ((four == `FOUR_K7_NEG || four == `FOUR_K7_POS) && lo_ok
                         && (lo == `LO_K23 || lo == `LO_K27 || lo == `LO_K29 || lo == `LO_K30)) begin
                if (lo == `LO_K30) begin
                    decode_group = {3'b001, `CHAR_K30_7}; // RULE9
                end else if (lo == `LO_K23) begin
                    decode_group = {3'b000, `CHAR_K23_7}; // RULE8
                end else if (lo == `LO_K27) begin
                    decode_group = {3'b000, `CHAR_K27_7}; // RULE8
                end else begin
                    decode_group = {3'b000, `CHAR_K29_7}; // RULE8
                end
            end else if (lo_ok && hi_ok) begin
                decode_group = {4'b0000, hi, lo}; // RULE2 RULE7
            end else begin
                decode_group = {3'b001, err_val}; // RULE9
            end
        end
    endfunction

    // -----------------------------------------------------------------------
    // mode decode
    // -----------------------------------------------------------------------
    wire       translate = idle_translate_enable | standard_lane_mode_enable; // RULE10
    wire       trunk_req = trunk_sync_pin && (receive_clock_select != `RCS_PER_LANE);
    wire       rate_same = (half_rate == 4'h0) || (half_rate == 4'hf);
    wire       trunk     = trunk_req && coding_active && rate_same; // RULE16
    wire       desk_on   = deskew_state_machine_enable | simple_align_enable; // RULE14 RULE15
    wire       fault_on  = local_fault && (standard_lane_mode_enable
                           || (standard_sync_select && deskew_state_machine_enable));
    wire [8:0] gen_idle  = translate ? {1'b1, idle_char} : `CHAR_K28_5; // RULE19
    reg        tick;

    always @* begin
        if (receive_clock_select == `RCS_LANE_A) begin
            tick = lane_valid[0]; // RULE17
        end else begin
            tick = 1'b1; // RULE17
        end
    end

    // -----------------------------------------------------------------------
    // per-lane write side and buffer state
    // -----------------------------------------------------------------------
    reg  [ADDR_WIDTH-1:0] wr_ptr [0:LANES-1];
    reg  [ADDR_WIDTH-1:0] rd_ptr [0:LANES-1];
    reg  [ADDR_WIDTH:0]   cnt    [0:LANES-1];
    reg  [ADDR_WIDTH-1:0] rd_addr_next [0:LANES-1];
    reg  [11:0]           dec    [0:LANES-1];
    reg  [11:0]           entry  [0:LANES-1];
    wire [11:0]           head   [0:LANES-1];
    reg  [3:0]            prev_idle;
    reg  [3:0]            stale;
    reg  [3:0]            push;
    reg  [3:0]            pop;
    reg  [3:0]            head_ok;
    reg  [3:0]            marks;
    integer               i;
    integer               j;
    integer               k;
    integer               m;

    always @* begin
        for (j = 0; j < LANES; j = j + 1) begin
            dec[j]   = decode_group(lane_code[j*10 +: 10], translate, idle_char, error_char);
            entry[j] = {dec[j][10] | (prev_idle[j] & ~dec[j][11]), dec[j][11], dec[j][9:0]}; // RULE12
            // drop idles once half of the compensation entries are used
            push[j]  = lane_valid[j] && (cnt[j] != DEPTH_CNT)
                       && !(dec[j][11] && cnt[j] >= FILL_HIGH); // RULE18 RULE19 RULE20
            head_ok[j] = (cnt[j] != {(ADDR_WIDTH+1){1'b0}}) && !stale[j];
            marks[j]   = head[j][`ENT_MARK];
            rd_addr_next[j] = pop[j] ? rd_ptr[j] + 1'b1 : rd_ptr[j];
        end
    end

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : lane
            lane_buffer #(
                .WIDTH      (`ENT_WIDTH),
                .ADDR_WIDTH (ADDR_WIDTH)
            ) u_buf (
                .sys_clk (sys_clk),
                .arst_n  (arst_n),
                .wr_en   (push[g]),
                .wr_addr (wr_ptr[g]),
                .wr_data (entry[g]),
                .rd_addr (rd_addr_next[g]),
                .rd_data (head[g])
            ); // RULE11 RULE18
        end
    endgenerate

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < LANES; i = i + 1) begin
                wr_ptr[i] <= {ADDR_WIDTH{1'b0}};
                rd_ptr[i] <= {ADDR_WIDTH{1'b0}};
                cnt[i]    <= {(ADDR_WIDTH+1){1'b0}};
            end
            prev_idle <= 4'h0;
            stale     <= 4'h0;
        end else begin
            for (i = 0; i < LANES; i = i + 1) begin
                if (push[i]) begin
                    wr_ptr[i] <= wr_ptr[i] + 1'b1;
                end
                if (lane_valid[i]) begin
                    prev_idle[i] <= dec[i][11];
                end
                rd_ptr[i] <= rd_addr_next[i];
                // read port lags a same-address write by one cycle
                stale[i]  <= push[i] && (wr_ptr[i] == rd_addr_next[i]);
                if (push[i] && !pop[i]) begin
                    cnt[i] <= cnt[i] + 1'b1;
                end else if (!push[i] && pop[i]) begin
                    cnt[i] <= cnt[i] - 1'b1;
                end
            end
        end
    end

    // -----------------------------------------------------------------------
    // read side: deskew decision
    // -----------------------------------------------------------------------
    reg       aligned;
    reg [2:0] miss;
    reg [3:0] stall_cnt;
    reg [3:0] emit;
    reg       emit_gen;
    reg       next_aligned;
    reg [2:0] next_miss;
    reg [3:0] next_stall;

    always @* begin
        pop          = 4'h0;
        emit         = 4'h0;
        emit_gen     = 1'b0;
        next_aligned = aligned;
        next_miss    = miss;
        next_stall   = stall_cnt;
        if (trunk) begin
            if (tick) begin
                emit = 4'hf;
                if (!(&head_ok)) begin
                    emit_gen = 1'b1; // RULE19
                end else if (!desk_on || marks == 4'h0 || marks == 4'hf) begin
                    pop        = 4'hf;
                    next_stall = 4'h0;
                    if (desk_on && marks == 4'hf) begin
                        next_aligned = 1'b1; // RULE12
                        next_miss    = 3'h0;
                    end
                end else if (deskew_state_machine_enable && aligned && miss < `HYST_LIMIT) begin
                    pop       = 4'hf; // RULE14
                    next_miss = miss + 1'b1;
                end else if (stall_cnt >= STALL_LIMIT) begin
                    pop        = 4'hf; // RULE21
                    next_stall = 4'h0;
                end else begin
                    // hold marked lanes while the late lanes catch up
                    pop          = ~marks; // RULE12 RULE13 RULE15
                    emit_gen     = 1'b1;
                    next_aligned = 1'b0;
                    next_stall   = stall_cnt + 1'b1;
                end
            end
        end else begin
            pop  = head_ok; // RULE22
            emit = head_ok; // RULE17
        end
    end

    // -----------------------------------------------------------------------
    // output column build
    // -----------------------------------------------------------------------
    reg  [35:0] saved_col;
    reg         last_nonidle;
    reg  [35:0] col;
    reg  [3:0]  col_err;
    reg  [3:0]  col_idle;
    reg  [35:0] next_char;
    reg  [3:0]  next_err;

    always @* begin
        for (k = 0; k < LANES; k = k + 1) begin
            col[k*9 +: 9] = emit_gen ? gen_idle : head[k][8:0];
            col_err[k]    = emit_gen ? 1'b0 : head[k][`ENT_ERR];
            col_idle[k]   = emit_gen ? 1'b1 : head[k][`ENT_IDLE];
        end
        next_char = col;
        next_err  = col_err;
        if (trunk && (&col_idle) && !last_nonidle) begin
            next_char = saved_col; // RULE5
        end
        if (fault_on) begin
            next_char = {`LF_LANE3, `LF_LANE2, `LF_LANE1, `LF_LANE0}; // RULE6
            next_err  = 4'h0;
        end
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_char       <= {4{`IDLE_COLUMN_RESET}};
            rx_err        <= 4'h0;
            rx_valid      <= 4'h0;
            lanes_aligned <= 1'b0;
            trunk_active  <= 1'b0;
            saved_col     <= {4{`IDLE_COLUMN_RESET}};
            last_nonidle  <= 1'b1;
            aligned       <= 1'b0;
            miss          <= 3'h0;
            stall_cnt     <= 4'h0;
        end else begin
            aligned       <= next_aligned;
            miss          <= next_miss;
            stall_cnt     <= next_stall;
            lanes_aligned <= trunk && next_aligned;
            trunk_active  <= trunk;
            rx_valid      <= emit;
            for (m = 0; m < LANES; m = m + 1) begin
                if (emit[m]) begin
                    rx_char[m*9 +: 9] <= next_char[m*9 +: 9];
                    rx_err[m]         <= next_err[m];
                end
            end
            if (trunk && emit[0]) begin
                last_nonidle <= !(&col_idle);
                if ((&col_idle) && last_nonidle) begin
                    saved_col <= col; // RULE5
                end
            end
        end
    end

endmodule

`default_nettype wire

// [dv/rx_decode_checker_sva.sv]
// port-level assertions for the four-lane receive decode block
`timescale 1ns/1ns
`default_nettype none
module rx_decode_checker (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic [39:0] lane_code,
    input wire logic [3:0]  lane_valid,
    input wire logic        idle_translate_enable,
    input wire logic        standard_lane_mode_enable,
    input wire logic        standard_sync_select,
    input wire logic        deskew_state_machine_enable,
    input wire logic [1:0]  receive_clock_select,
    input wire logic        trunk_sync_pin,
    input wire logic        coding_active,
    input wire logic [3:0]  half_rate,
    input wire logic [7:0]  idle_char,
    input wire logic        local_fault,
    input wire logic [35:0] rx_char,
    input wire logic [3:0]  rx_err,
    input wire logic [3:0]  rx_valid,
    input wire logic        trunk_active
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    wire translate = idle_translate_enable | standard_lane_mode_enable;
    wire lf_mode   = standard_lane_mode_enable | (standard_sync_select & deskew_state_machine_enable);
    wire trunk_req = trunk_sync_pin & (receive_clock_select != 2'h1) & coding_active & (half_rate == 4'h0 | half_rate == 4'hf);
    chk_data_byte: assert property (lane_valid[0] && lane_code[9:0] == 10'h155 && !trunk_active |-> ##3
        (trunk_active || local_fault || rx_valid[0] && rx_char[8:0] == 9'h0b5 && !rx_err[0])) else $error("data decode wrong");
    chk_error_group: assert property (lane_valid[0] && lane_code[9:0] == 10'h05e && !trunk_active |-> ##3
        (trunk_active || local_fault || rx_valid[0] && rx_char[8:0] == 9'h1fe && rx_err[0])) else $error("error group wrong");
    chk_idle_swap: assert property (lane_valid[1] && lane_code[19:10] == 10'h17c && translate && !trunk_active |-> ##3
        (trunk_active || local_fault || rx_char[17:9] == {1'b1, idle_char} && !rx_err[1])) else $error("idle not swapped");
    chk_lane_answer: assert property (!trunk_active && lane_valid[3] |-> ##[3:40] (rx_valid[3] || trunk_active))
        else $error("lane char missing");
    chk_fault_column: assert property ((rx_valid[0] || rx_valid[3]) && local_fault && $past(local_fault) && $past(local_fault, 2)
        && $past(local_fault, 3) && lf_mode && $past(lf_mode, 3) |-> (!rx_valid[0] || rx_char[8:0] == 9'h19c)
        && (!rx_valid[3] || rx_char[35:27] == 9'h001)) else $error("fault column wrong");
    chk_trunk_gate: assert property (trunk_active |-> $past(trunk_req)) else $error("trunk without conditions");
    chk_trunk_follow: assert property ($past(trunk_req) |-> trunk_active) else $error("trunk not entered");
    chk_trunk_stream: assert property (trunk_active && $past(trunk_active) && $past(trunk_active, 2)
        && receive_clock_select == 2'h0 && $past(receive_clock_select) == 2'h0 |-> rx_valid == 4'hf) else $error("column gap");
endmodule
bind rx_decode_deskew_elastic rx_decode_checker u_chk (.*);
`default_nettype wire

// [dv/remote_lane_tx.sv]
// remote transmitter model: one code group per lane per beat
`timescale 1ns/1ns
`default_nettype none
module remote_lane_tx (
    input  wire logic        sys_clk,
    input  wire logic        send,
    input  wire logic [19:0] sel,
    output var  logic [39:0] lane_code,
    output var  logic [3:0]  lane_valid
);
    // bit 0 holds a, bit 9 holds j
    localparam logic [9:0] code_tab [0:16] = '{10'h0b9, 10'h36e, 10'h2aa, 10'h155, 10'h05b, 10'h05d, 10'h27c,
        10'h2bc, 10'h13c, 10'h1bc, 10'h07c, 10'h057, 10'h05e, 10'h17c, 10'h33c, 10'h0bc, 10'h000};
    initial begin
        lane_code = 40'h0;
        lane_valid = 4'h0;
    end
    // all lanes launched together; released lines show the inverse
    always @(posedge sys_clk) begin
        lane_valid <= {4{send}};
        for (int n = 0; n < 4; n++)
            lane_code[n*10+:10] <= send ? code_tab[sel[n*5+:5]] : ~lane_code[n*10+:10];
    end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the four-lane receive decode block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        sys_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        send_en = 1'b0, watch = 1'b0, trunk_sync_pin = 1'b0, local_fault = 1'b0, simple_align_enable = 1'b0;
    logic [19:0] sel = 20'h0;
    logic [39:0] lane_code;
    logic [3:0]  lane_valid;
    logic        idle_translate_enable = 1'b0, standard_lane_mode_enable = 1'b0, standard_sync_select = 1'b0;
    logic        deskew_state_machine_enable = 1'b0;
    logic [1:0]  receive_clock_select = 2'h1;
    logic        coding_active = 1'b1;
    logic [3:0]  half_rate = 4'h0;
    logic [7:0]  idle_char = 8'h07;
    logic [8:0]  error_char = 9'h1ff;
    logic [35:0] rx_char;
    logic [3:0]  rx_err, rx_valid;
    logic        lanes_aligned, trunk_active;
    logic [9:0]  got;
    logic [9:0]  exp_q [4][$];
    int          n_mismatch = 0;
    int          compares = 0;
    localparam logic [9:0] exp_tab [0:15] = '{10'h000, 10'h001, 10'h04a, 10'h0b5, 10'h1fb, 10'h1fd, 10'h13c,
        10'h15c, 10'h19c, 10'h1dc, 10'h1fc, 10'h1f7, 10'h3fe, 10'h1bc, 10'h17c, 10'h11c};

    always #10 sys_clk = ~sys_clk;

    remote_lane_tx far_end (.sys_clk, .send(send_en), .sel, .lane_code, .lane_valid);
    rx_decode_deskew_elastic DUT (.*);

    function automatic logic [9:0] expect_of(input logic [4:0] idx, input int lane);
        if (local_fault && (standard_lane_mode_enable || (standard_sync_select && deskew_state_machine_enable)))
            return lane == 0 ? 10'h19c : (lane == 3 ? 10'h001 : 10'h000);
        if (idx == 5'd16)
            return {1'b1, error_char};
        if (idx >= 5'd13 && (idle_translate_enable || standard_lane_mode_enable))
            return {2'b01, idle_char};
        return exp_tab[idx[3:0]];
    endfunction

    function automatic logic [19:0] rnd_sel();
        for (int n = 0; n < 4; n++)
            rnd_sel[n*5+:5] = 5'($urandom % 17);
    endfunction

    task automatic send(input logic [19:0] s);
        @(negedge sys_clk);
        sel = s;
        send_en = 1'b1;
        for (int n = 0; n < 4; n++)
            exp_q[n].push_back(expect_of(s[n*5+:5], n));
        @(negedge sys_clk);
        send_en = 1'b0;
        repeat (5) @(negedge sys_clk);
    endtask

    task automatic chk(input logic [40:0] g, input logic [40:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic complete_run();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(negedge sys_clk) begin
        if (watch) begin
            for (int n = 0; n < 4; n++) begin
                if (rx_valid[n] === 1'b1) begin
                    got = {rx_err[n], rx_char[n*9+:9]};
                    compares++;
                    if (exp_q[n].size() == 0 || got !== exp_q[n][0]) begin
                        n_mismatch++;
                        $display("CHECK FAILED at %0t: lane %0d got %h", $time, n, got);
                    end
                    if (exp_q[n].size() != 0)
                        void'(exp_q[n].pop_front());
                end
            end
        end
    end

    initial begin
        #400000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h20e914e2));
        repeat (12) @(negedge sys_clk);
        chk({rx_valid, trunk_active, rx_char}, {5'h0, {4{9'h107}}});
        arst_n = 1'b1;
        watch = 1'b1;
        for (int i = 0; i < 17; i++)
            send({4{5'(i)}});
        idle_char = 8'($urandom);
        error_char = 9'($urandom);
        idle_translate_enable = 1'b1;
        for (int i = 13; i < 17; i++)
            send({4{5'(i)}});
        idle_translate_enable = 1'b0;
        standard_lane_mode_enable = 1'b1;
        for (int i = 13; i < 16; i++)
            send({4{5'(i)}});
        local_fault = 1'b1;
        send({4{5'd3}});
        standard_lane_mode_enable = 1'b0;
        standard_sync_select = 1'b1;
        deskew_state_machine_enable = 1'b1;
        send({4{5'd3}});
        deskew_state_machine_enable = 1'b0;
        send({4{5'd3}});
        local_fault = 1'b0;
        for (int r = 0; r < 40; r++) begin
            idle_char = 8'($urandom);
            error_char = 9'($urandom);
            idle_translate_enable = 1'($urandom);
            send(rnd_sel());
        end
        watch = 1'b0;
        idle_translate_enable = 1'b1;
        receive_clock_select = 2'h0;
        trunk_sync_pin = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk({rx_valid, trunk_active, rx_char}, {5'h1f, {4{1'b1, idle_char}}});
        half_rate = 4'h1;
        repeat (3) @(negedge sys_clk);
        chk({39'h0, lanes_aligned, trunk_active}, 41'h0);
        half_rate = 4'h0;
        coding_active = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk({40'h0, trunk_active}, 41'h0);
        complete_run();
    end
endmodule
`default_nettype wire
